// ==== design/sac_pkg.sv ====
// Constants, register indices and types for the converter control block.
// Assumes a single 50 MHz system clock and byte-wide special function register access.
// Functional notes
// [R1] Right justify: result in low twelve bits.
// [R2] Right justify: upper nibble sign or zero.
// [R3] Left justify: result high, low nibble zero.
// [R4] Code scales by two to twelve or eleven.
// [R5] Differential results are two's complement values.
// [R6] Every result compared against limits, flag set.
// [R7] Software writes limits as byte pairs.
// [R8] Limit order selects inside or outside window.
// [R9] Window flag pollable and usable for interrupts; there is no interrupt output here, only the control register bit.
// [R10] Converter runs only while enable is one.
// [R11] Start mode selects software, timers or pin.
// [R12] Converter clock divided from system clock.
// [R13] Completion updates data, clears busy, sets flag.
// [R14] Low-power tracking lasts three converter clocks; in pin mode the code instead tracks while the pin is low.
package sac_pkg;
  localparam int RES_BITS = 12;
  localparam int DIV_BITS = 6;
  localparam logic [3:0] IDX_CONTROL = 4'h0;
  localparam logic [3:0] IDX_DATA_HIGH = 4'h1;
  localparam logic [3:0] IDX_DATA_LOW = 4'h2;
  localparam logic [3:0] IDX_CONFIG = 4'h3;
  localparam logic [3:0] IDX_UPPER_HIGH = 4'h4;
  localparam logic [3:0] IDX_UPPER_LOW = 4'h5;
  localparam logic [3:0] IDX_LOWER_HIGH = 4'h6;
  localparam logic [3:0] IDX_LOWER_LOW = 4'h7;
  localparam logic [7:0] CONTROL_RESET = 8'h00;
  localparam logic [7:0] CONFIG_RESET = 8'hF8;
  localparam logic [7:0] DATA_RESET = 8'h00;
  localparam logic [15:0] UPPER_RESET = 16'hFFFF;
  localparam logic [15:0] LOWER_RESET = 16'h0000;
  localparam int B_ENABLE = 7;
  localparam int B_TRACK_MODE = 6;
  localparam int B_DONE = 5;
  localparam int B_BUSY = 4;
  localparam int B_MODE_HI = 3;
  localparam int B_MODE_LO = 2;
  localparam int B_WINDOW = 1;
  localparam int B_LJUST = 0;
  localparam logic [1:0] MODE_SOFTWARE = 2'h0;
  localparam logic [1:0] MODE_TIMER3 = 2'h1;
  localparam logic [1:0] MODE_PIN = 2'h2;
  localparam logic [1:0] MODE_TIMER2 = 2'h3;
  localparam logic [1:0] TRACK_TICKS = 2'h3;
  localparam logic [11:0] SAR_MSB = 12'h800;
  localparam logic [3:0] NIBBLE_ZERO = 4'h0;
  typedef enum {ST_IDLE, ST_TRACK, ST_CONV} sac_state_t;
endpackage

// ==== design/sac_sar_if.sv ====
// Carrier between the control logic and the successive approximation engine.
// Assumes both ends run on the same system clock.
interface sac_sar_if;
  logic start;
  logic tick;
  logic comp;
  logic done;
  logic [11:0] result;
  logic [11:0] dac_code;
  modport ctrl (output start, output tick, output comp, input done, input result,
    input dac_code);
  modport engine (input start, input tick, input comp, output done, output result,
    output dac_code);
endinterface

// ==== design/sac_sar_engine.sv ====
// Successive approximation engine: one trial bit per converter clock enable.
// Assumes a synchronised comparator level, high while the input is at or above the trial code.
module sac_sar_engine
  import sac_pkg::*;
(
  input wire logic clk,
  input wire logic srst,
  sac_sar_if.engine bus
);
  logic running;
  logic next_running;
  logic [11:0] trial_bit;
  logic [11:0] next_trial_bit;
  logic [11:0] code;
  logic [11:0] next_code;
  logic done;
  logic next_done;

  // ----------------------------------------
  // Bit trials
  // ----------------------------------------
  always_comb begin
    next_running = running;
    next_trial_bit = trial_bit;
    next_code = code;
    next_done = 1'b0;
    if (bus.start) begin
      next_running = 1'b1;
      next_trial_bit = SAR_MSB;
      next_code = SAR_MSB;
    end else if (running && bus.tick) begin
      if (!bus.comp) begin
        next_code = code & ~trial_bit;
      end
      next_trial_bit = trial_bit >> 1;
      next_code = next_code | (trial_bit >> 1);
      if (trial_bit[0]) begin
        next_running = 1'b0;
        next_done = 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      running <= 1'b0;
      trial_bit <= '0;
      code <= '0;
      done <= 1'b0;
    end else begin
      running <= next_running;
      trial_bit <= next_trial_bit;
      code <= next_code;
      done <= next_done;
    end
  end

  assign bus.done = done;
  assign bus.result = code;
  assign bus.dac_code = code;
endmodule

// ==== design/sac_top.sv ====
// Converter control: registers, start selection, tracking, formatting, window detector.
// Assumes timer overflows are one-cycle pulses on clk; pins arrive asynchronously.
module sac_top
  import sac_pkg::*;
(
  input wire logic clk,
  input wire logic srst,
  input wire logic [3:0] reg_sel,
  input wire logic reg_wr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  input wire logic timer2_overflow,
  input wire logic timer3_overflow,
  input wire logic external_start_pin,
  input wire logic comparator_in,
  input wire logic differential_reading,
  output logic analog_enable,
  output logic track_enable,
  output logic [2:0] pga_gain,
  output logic [11:0] dac_code
);
  sac_sar_if bus ();

  sac_sar_engine u_engine (
    .clk(clk),
    .srst(srst),
    .bus(bus)
  );

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  logic pin_s1;
  logic pin_s2;
  logic pin_s3;
  logic comp_s1;
  logic comp_s2;

  always_ff @(posedge clk) begin
    if (srst) begin
      pin_s1 <= 1'b1;
      pin_s2 <= 1'b1;
      pin_s3 <= 1'b1;
      comp_s1 <= 1'b0;
      comp_s2 <= 1'b0;
    end else begin
      pin_s1 <= external_start_pin;
      pin_s2 <= pin_s1;
      pin_s3 <= pin_s2;
      comp_s1 <= comparator_in;
      comp_s2 <= comp_s1;
    end
  end

  logic pin_rise;
  assign pin_rise = pin_s2 && !pin_s3;
  assign bus.comp = comp_s2;

  // ----------------------------------------
  // Registers and control state
  // ----------------------------------------
  logic [7:0] control;
  logic [7:0] next_control;
  logic [7:0] config_reg;
  logic [7:0] next_config_reg;
  logic [7:0] data_high;
  logic [7:0] next_data_high;
  logic [7:0] data_low;
  logic [7:0] next_data_low;
  logic [15:0] upper_limit;
  logic [15:0] next_upper_limit;
  logic [15:0] lower_limit;
  logic [15:0] next_lower_limit;
  logic [7:0] next_reg_rdata;
  sac_state_t state;
  sac_state_t next_state;
  logic [1:0] track_cnt;
  logic [1:0] next_track_cnt;
  logic [DIV_BITS-1:0] div_cnt;
  logic [DIV_BITS-1:0] next_div_cnt;
  logic tick;
  logic next_tick;
  logic start;
  logic next_start;
  logic next_analog_enable;
  logic next_track_enable;

  logic [1:0] mode;
  logic sw_start;
  logic trigger;
  logic [11:0] value;
  logic [15:0] word;
  logic above;
  logic below;
  logic win_hit;
  logic [4:0] divider;

  assign mode = control[B_MODE_HI:B_MODE_LO];
  assign divider = config_reg[7:3];
  assign sw_start = reg_wr && (reg_sel == IDX_CONTROL) && reg_wdata[B_BUSY];

  // ----------------------------------------
  // Result formatting and window compare
  // ----------------------------------------
  always_comb begin
    // Offset binary from the engine becomes two's complement for differential pairs.
    value = differential_reading ? (bus.result ^ SAR_MSB) : bus.result; // [R4] [R5]
    if (control[B_LJUST]) begin
      word = {value, NIBBLE_ZERO}; // [R3]
    end else if (differential_reading) begin
      word = {{4{value[RES_BITS-1]}}, value}; // [R1] [R2]
    end else begin
      word = {NIBBLE_ZERO, value}; // [R1] [R2]
    end
    if (differential_reading) begin
      above = $signed(word) > $signed(upper_limit);
      below = $signed(word) < $signed(lower_limit);
      win_hit = ($signed(lower_limit) > $signed(upper_limit)) ? (above && below)
                                                              : (above || below); // [R8]
    end else begin
      above = word > upper_limit;
      below = word < lower_limit;
      win_hit = (lower_limit > upper_limit) ? (above && below) : (above || below); // [R8]
    end
  end

  always_comb begin
    case (mode)
      MODE_SOFTWARE: trigger = sw_start; // [R11]
      MODE_TIMER3: trigger = timer3_overflow; // [R11]
      MODE_PIN: trigger = pin_rise; // [R11]
      default: trigger = timer2_overflow; // [R11]
    endcase
  end

  // ----------------------------------------
  // Next-state logic
  // ----------------------------------------
  always_comb begin
    next_control = control;
    next_config_reg = config_reg;
    next_data_high = data_high;
    next_data_low = data_low;
    next_upper_limit = upper_limit;
    next_lower_limit = lower_limit;
    next_state = state;
    next_track_cnt = track_cnt;
    next_start = 1'b0;
    if (reg_wr) begin
      case (reg_sel)
        IDX_CONTROL: next_control = {reg_wdata[7:5], control[B_BUSY], reg_wdata[3:0]};
        IDX_CONFIG: next_config_reg = reg_wdata;
        IDX_DATA_HIGH: next_data_high = reg_wdata;
        IDX_DATA_LOW: next_data_low = reg_wdata;
        IDX_UPPER_HIGH: next_upper_limit[15:8] = reg_wdata;
        IDX_UPPER_LOW: next_upper_limit[7:0] = reg_wdata;
        IDX_LOWER_HIGH: next_lower_limit[15:8] = reg_wdata;
        IDX_LOWER_LOW: next_lower_limit[7:0] = reg_wdata;
        default: next_control = control;
      endcase
    end
    case (state)
      ST_IDLE: begin
        if (control[B_ENABLE] && trigger) begin
          next_control[B_BUSY] = 1'b1;
          if (control[B_TRACK_MODE] && (mode != MODE_PIN)) begin
            next_state = ST_TRACK; // [R14]
            next_track_cnt = '0;
          end else begin
            next_state = ST_CONV;
            next_start = 1'b1;
          end
        end
      end
      ST_TRACK: begin
        if (tick) begin
          next_track_cnt = track_cnt + 1'b1;
          if (track_cnt == TRACK_TICKS - 1'b1) begin
            next_state = ST_CONV; // [R14]
            next_start = 1'b1;
          end
        end
      end
      ST_CONV: begin
        if (bus.done) begin
          next_state = ST_IDLE;
          next_control[B_BUSY] = 1'b0; // [R13]
          next_control[B_DONE] = 1'b1; // [R13]
          if (win_hit) begin
            next_control[B_WINDOW] = 1'b1; // [R6] [R9]
          end
          next_data_high = word[15:8]; // [R13]
          next_data_low = word[7:0];
        end
      end
      default: next_state = ST_IDLE;
    endcase
    if (!next_control[B_ENABLE]) begin
      next_state = ST_IDLE; // [R10]
      next_control[B_BUSY] = 1'b0;
      next_start = 1'b0;
    end
    // A start restarts the converter clock so that, with a nonzero divider, the first trial sees a settled comparator.
    if ((div_cnt == '0) || next_start) begin
      next_div_cnt = {divider, 1'b1}; // [R12]
    end else begin
      next_div_cnt = div_cnt - 1'b1;
    end
    next_tick = ((div_cnt == '0) || (divider == '0)) && !next_start; // [R12]
    next_analog_enable = next_control[B_ENABLE]; // [R10]
    if (!next_control[B_ENABLE]) begin
      next_track_enable = 1'b0;
    end else if (next_state == ST_IDLE) begin
      next_track_enable = !next_control[B_TRACK_MODE] ||
                          ((next_control[B_MODE_HI:B_MODE_LO] == MODE_PIN) && !pin_s2); // [R14]
    end else begin
      next_track_enable = (next_state == ST_TRACK);
    end
    case (reg_sel)
      IDX_CONTROL: next_reg_rdata = control;
      IDX_CONFIG: next_reg_rdata = config_reg;
      IDX_DATA_HIGH: next_reg_rdata = data_high;
      IDX_DATA_LOW: next_reg_rdata = data_low;
      IDX_UPPER_HIGH: next_reg_rdata = upper_limit[15:8];
      IDX_UPPER_LOW: next_reg_rdata = upper_limit[7:0];
      IDX_LOWER_HIGH: next_reg_rdata = lower_limit[15:8];
      IDX_LOWER_LOW: next_reg_rdata = lower_limit[7:0];
      default: next_reg_rdata = 8'h00;
    endcase
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      control <= CONTROL_RESET;
      config_reg <= CONFIG_RESET;
      data_high <= DATA_RESET;
      data_low <= DATA_RESET;
      upper_limit <= UPPER_RESET;
      lower_limit <= LOWER_RESET;
      state <= ST_IDLE;
      track_cnt <= '0;
      div_cnt <= '0;
      tick <= 1'b0;
      start <= 1'b0;
      analog_enable <= 1'b0;
      track_enable <= 1'b0;
      reg_rdata <= 8'h00;
      pga_gain <= CONFIG_RESET[2:0];
    end else begin
      control <= next_control;
      config_reg <= next_config_reg;
      data_high <= next_data_high;
      data_low <= next_data_low;
      upper_limit <= next_upper_limit;
      lower_limit <= next_lower_limit;
      state <= next_state;
      track_cnt <= next_track_cnt;
      div_cnt <= next_div_cnt;
      tick <= next_tick;
      start <= next_start;
      analog_enable <= next_analog_enable;
      track_enable <= next_track_enable;
      reg_rdata <= next_reg_rdata;
      pga_gain <= next_config_reg[2:0];
    end
  end

  assign bus.start = start;
  assign bus.tick = tick;
  assign dac_code = bus.dac_code;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  logic cpl;
  assign cpl = (state == ST_CONV) && bus.done && control[B_ENABLE];

  a_done_sets_flag: assert property (@(posedge clk) disable iff (srst) // [R13]
    cpl && !reg_wr |=> control[B_DONE] && !control[B_BUSY]) else $error("done flag missing");
  a_rjust_low: assert property (@(posedge clk) disable iff (srst) // [R1]
    cpl && !control[B_LJUST] && !reg_wr |=> data_low == $past(value[7:0]))
    else $error("right justified low byte wrong");
  a_rjust_sign: assert property (@(posedge clk) disable iff (srst) // [R2]
    cpl && !control[B_LJUST] && !reg_wr |=>
    data_high[7:4] == ($past(differential_reading) ? {4{$past(value[11])}} : 4'h0))
    else $error("right justified upper nibble wrong");
  a_ljust_layout: assert property (@(posedge clk) disable iff (srst) // [R3]
    cpl && control[B_LJUST] && !reg_wr |=>
    data_low[3:0] == 4'h0 && data_high == $past(value[11:4])) else $error("left justify wrong");
  a_window_set: assert property (@(posedge clk) disable iff (srst) // [R6]
    cpl && win_hit |=> control[B_WINDOW]) else $error("window flag missing");
  a_off_idle: assert property (@(posedge clk) disable iff (srst) // [R10]
    !control[B_ENABLE] |-> state == ST_IDLE && !analog_enable) else $error("runs while off");
  a_sw_start: assert property (@(posedge clk) disable iff (srst) // [R11]
    state == ST_IDLE && control[B_ENABLE] && mode == MODE_SOFTWARE && sw_start &&
    reg_wdata[B_ENABLE] |=> control[B_BUSY] && state != ST_IDLE) else $error("no start");
  a_div_gap: assert property (@(posedge clk) disable iff (srst) // [R12]
    tick && divider != 5'h00 && $stable(divider) |=> !tick) else $error("divider too fast");
  a_track_conv: assert property (@(posedge clk) disable iff (srst) // [R14]
    state == ST_TRACK && tick && track_cnt == 2'h2 && control[B_ENABLE] && !reg_wr
    |=> state == ST_CONV && start) else $error("tracking length wrong");
endmodule

// ==== tb/sac_analog_model.sv ====
// Far-side analogue model: a held input level against the converter's trial code.
// Assumes the trial code settles on clk and the comparator output is synchronised downstream.
module sac_analog_model (
  input wire logic analog_enable,
  input wire logic [11:0] dac_code,
  input wire logic [11:0] level,
  output logic comparator_in
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------
  // Comparator
  // ----------------------------------------
  // In shutdown the output carries the inverse of the live result.
  assign comparator_in = analog_enable ? (level >= dac_code) : (level < dac_code);
endmodule

// ==== tb/sac_top_tb_top.sv ====
// Self-checking bench for the converter control block.
// Assumes the design package is compiled first and the analogue model beside it.
`define CHK(got, exp) \
  begin \
    total_checks++; \
    if ((got) !== (exp)) begin \
      mismatches++; \
      $display("ERROR %0t: got %h expected %h", $time, got, exp); \
    end \
  end
module sac_top_tb_top
  import sac_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 0;
  logic srst = 1;
  logic [3:0] reg_sel = 4'h0;
  logic reg_wr = 0;
  logic [7:0] reg_wdata = 8'h00;
  logic [7:0] reg_rdata;
  logic timer2_overflow = 0;
  logic timer3_overflow = 0;
  logic external_start_pin = 1;
  logic comparator_in;
  logic differential_reading = 0;
  logic analog_enable;
  logic track_enable;
  logic [2:0] pga_gain;
  logic [11:0] dac_code;
  logic [11:0] level = 12'h000;
  int mismatches = 0;
  int total_checks = 0;
  // ----------------------------------------
  // Clock, design and model
  // ----------------------------------------
  always #10 clk = ~clk;
  sac_top dut (.clk(clk), .srst(srst), .reg_sel(reg_sel), .reg_wr(reg_wr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .timer2_overflow(timer2_overflow),
    .timer3_overflow(timer3_overflow), .external_start_pin(external_start_pin),
    .comparator_in(comparator_in), .differential_reading(differential_reading),
    .analog_enable(analog_enable), .track_enable(track_enable), .pga_gain(pga_gain),
    .dac_code(dac_code));
  sac_analog_model model (.analog_enable(analog_enable), .dac_code(dac_code), .level(level),
    .comparator_in(comparator_in));
  // ----------------------------------------
  // Bus tasks
  // ----------------------------------------
  task automatic wr(input logic [3:0] s, input logic [7:0] d);
    reg_sel = s;
    reg_wdata = d;
    reg_wr = 1;
    @(posedge clk);
    #1;
    reg_wr = 0;
    @(posedge clk);
    #1;
  endtask
  task automatic rd(input logic [3:0] s, output logic [7:0] d);
    reg_sel = s;
    repeat (2) @(posedge clk);
    #1;
    d = reg_rdata;
  endtask
  task automatic stop_test();
    $display("mismatches %0d total_checks %0d", mismatches, total_checks);
    if (mismatches == 0 && total_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic reset_values();
    logic [7:0] d;
    rd(IDX_CONTROL, d);
    `CHK(d, 8'h00)
    `CHK(analog_enable, 1'b0)
    `CHK(track_enable, 1'b0)
    rd(IDX_CONFIG, d);
    `CHK(d, 8'hF8)
    wr(4'hF, 8'hFF);
    rd(4'hF, d);
    `CHK(d, 8'h00)
    wr(IDX_CONFIG, 8'h1D);
    rd(IDX_CONFIG, d);
    `CHK(d, 8'h1D)
    `CHK(pga_gain, 3'h5)
  endtask
  task automatic conv(input logic [1:0] mode, input logic tm, input logic lj, input logic dif,
      input logic [11:0] lvl, input logic [15:0] up, input logic [15:0] lo);
    logic [7:0] d;
    logic [7:0] h;
    logic [7:0] l;
    logic [11:0] r;
    logic [15:0] w;
    logic hit;
    int n;
    level = lvl;
    differential_reading = dif;
    wr(IDX_UPPER_HIGH, up[15:8]);
    wr(IDX_UPPER_LOW, up[7:0]);
    wr(IDX_LOWER_HIGH, lo[15:8]);
    wr(IDX_LOWER_LOW, lo[7:0]);
    wr(IDX_CONTROL, {1'b1, tm, 2'b00, mode, 1'b0, lj});
    case (mode)
      MODE_SOFTWARE: wr(IDX_CONTROL, {1'b1, tm, 2'b01, mode, 1'b0, lj});
      MODE_TIMER3: begin
        timer3_overflow = 1;
        @(posedge clk);
        #1;
        timer3_overflow = 0;
      end
      MODE_PIN: begin
        `CHK(track_enable, !tm)
        external_start_pin = 0;
        repeat (6) @(posedge clk);
        #1;
        `CHK(track_enable, 1'b1)
        external_start_pin = 1;
      end
      default: begin
        timer2_overflow = 1;
        @(posedge clk);
        #1;
        timer2_overflow = 0;
      end
    endcase
    repeat (5) @(posedge clk);
    #1;
    rd(IDX_CONTROL, d);
    `CHK(d[B_BUSY], 1'b1)
    `CHK(analog_enable, 1'b1)
    `CHK(track_enable, tm && (mode != MODE_PIN))
    n = 0;
    while (d[B_BUSY] !== 1'b0 && n < 200) begin
      rd(IDX_CONTROL, d);
      n++;
    end
    `CHK(d[B_BUSY], 1'b0)
    `CHK(d[B_DONE], 1'b1)
    r = dif ? (lvl ^ SAR_MSB) : lvl;
    w = lj ? {r, 4'h0} : {(dif ? {4{r[11]}} : 4'h0), r};
    rd(IDX_DATA_HIGH, h);
    rd(IDX_DATA_LOW, l);
    `CHK(h, w[15:8])
    `CHK(l, w[7:0])
    if (dif) begin
      hit = ($signed(lo) > $signed(up)) ? ($signed(w) > $signed(up) && $signed(w) < $signed(lo))
        : ($signed(w) > $signed(up) || $signed(w) < $signed(lo));
    end else begin
      hit = (lo > up) ? (w > up && w < lo) : (w > up || w < lo);
    end
    `CHK(d[B_WINDOW], hit)
    wr(IDX_CONTROL, 8'h80);
    rd(IDX_CONTROL, d);
    `CHK(d[B_DONE], 1'b0)
    `CHK(d[B_WINDOW], 1'b0)
    `CHK(track_enable, 1'b1)
  endtask
  task automatic abort_and_refuse();
    logic [7:0] d;
    wr(IDX_CONTROL, 8'h10);
    rd(IDX_CONTROL, d);
    `CHK(d[B_BUSY], 1'b0)
    wr(IDX_CONTROL, 8'h80);
    wr(IDX_CONTROL, 8'h90);
    repeat (3) @(posedge clk);
    #1;
    rd(IDX_CONTROL, d);
    `CHK(d[B_BUSY], 1'b1)
    wr(IDX_CONTROL, 8'h00);
    repeat (200) @(posedge clk);
    #1;
    rd(IDX_CONTROL, d);
    `CHK(d, 8'h00)
    `CHK(analog_enable, 1'b0)
    `CHK(track_enable, 1'b0)
  endtask
  // ----------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------
  initial begin
    repeat (2) @(posedge clk);
    #1;
    srst = 0;
    reset_values();
    conv(MODE_SOFTWARE, 1'b0, 1'b0, 1'b0, 12'hABC, 16'hFFFF, 16'h0000);
    conv(MODE_TIMER3, 1'b0, 1'b1, 1'b0, 12'h7FF, 16'h1000, 16'h9000);
    conv(MODE_PIN, 1'b0, 1'b0, 1'b1, 12'h000, 16'h0000, 16'h0000);
    conv(MODE_TIMER2, 1'b1, 1'b1, 1'b1, 12'hFFF, 16'h8000, 16'h7000);
    conv(MODE_SOFTWARE, 1'b1, 1'b0, 1'b0, 12'h001, 16'h0000, 16'h0FFF);
    conv(MODE_PIN, 1'b1, 1'b1, 1'b0, 12'h800, 16'h7000, 16'h9000);
    abort_and_refuse();
    stop_test();
  end
  initial begin
    #100000;
    mismatches++;
    stop_test();
  end
endmodule
